// ### testbench/ltf_flags_sva.sv
// ltf_flags_sva: port-level checks of the ready and wakeup-timeout flag bank
// assumes it is bound to ltf_flags and sees only that module's ports
`timescale 1ns/10ps
module ltf_flags_sva #(
    parameter int unsigned EXPIRY_CYCLES = 20
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // transmitter side
    input wire logic        shift_load,
    input wire logic        tx_data_valid,
    input wire logic [7:0]  compat_tx_data_buffer,
    input wire logic [31:0] frame_tx_buffer_low,
    input wire logic [31:0] frame_tx_buffer_high,
    // wakeup side and interrupt
    input wire logic        wakeup_sent,
    input wire logic        synch_break,
    input wire logic        wakeup_hold,
    input wire logic        irq
);
    logic [4:0]  ctrl_q;
    logic [1:0]  mask_q;
    int unsigned hold_q;
    logic        txon;
    logic        linon;
    assign txon  = ctrl_q[4] & ctrl_q[1] & ~ctrl_q[0];
    assign linon = ctrl_q[2] & ctrl_q[1] & ~ctrl_q[0];
    // shadows rebuilt from port writes, the bodies stay unseen
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= 5'h00;
            mask_q <= 2'h0;
        end else if (wr && addr == ltf_pkg::OFS_CTRL) begin
            ctrl_q <= wdata[4:0];
        end else if (wr && addr == ltf_pkg::OFS_IRQ_MASK) begin
            mask_q <= wdata[1:0];
        end else if (wr && addr == ltf_pkg::OFS_IRQ_EN_CLR) begin
            mask_q <= mask_q & ~wdata[1:0];
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= 0;
        end else begin
            hold_q <= wakeup_hold ? hold_q + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_rdata_quiet: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    chk_write_clears: assert property (
        wr && txon && !shift_load && (ctrl_q[2] ? addr == ltf_pkg::OFS_FRAME_LOW
        : addr == ltf_pkg::OFS_COMPAT_TD) |=> tx_data_valid)
        else $error("buffer write did not clear ready");
    chk_upper_keeps: assert property (
        wr && linon && !tx_data_valid && (addr == ltf_pkg::OFS_FRAME_LOUP
        || addr == ltf_pkg::OFS_FRAME_HIGH) |=> !tx_data_valid)
        else $error("upper byte write cleared ready");
    chk_load_sets: assert property (shift_load && tx_data_valid |=> !tx_data_valid)
        else $error("shift load did not set ready");
    chk_load_irq: assert property (shift_load && tx_data_valid && mask_q[0] && !wr |=> irq)
        else $error("no transmit interrupt after load");
    chk_irq_withdrawn: assert property (
        wr && !mask_q[1] && !shift_load && ((addr == ltf_pkg::OFS_IRQ_EN_CLR && wdata[0])
        || (addr == ltf_pkg::OFS_CTRL && !wdata[4])) |=> !irq)
        else $error("transmit interrupt not withdrawn");
    chk_vector_keeps: assert property (
        rd && addr == ltf_pkg::OFS_VECTOR && !shift_load |=> $stable(tx_data_valid))
        else $error("vector read changed ready");
    chk_compat_idle: assert property (!linon [*3] |-> !wakeup_hold)
        else $error("wakeup expiry running outside lin mode");
    chk_hold_bound: assert property (wakeup_hold |-> hold_q < EXPIRY_CYCLES)
        else $error("expiry hold runs too long");
    chk_hold_full: assert property (
        $fell(wakeup_hold) && $past(linon) && !$past(synch_break) && !$past(wr)
        |-> hold_q == EXPIRY_CYCLES)
        else $error("expiry hold ended early");
endmodule : ltf_flags_sva

bind ltf_flags ltf_flags_sva #(.EXPIRY_CYCLES(EXPIRY_CYCLES)) i_sva (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .shift_load(shift_load), .tx_data_valid(tx_data_valid),
    .compat_tx_data_buffer(compat_tx_data_buffer), .frame_tx_buffer_low(frame_tx_buffer_low),
    .frame_tx_buffer_high(frame_tx_buffer_high), .wakeup_sent(wakeup_sent),
    .synch_break(synch_break), .wakeup_hold(wakeup_hold), .irq(irq));

// ### testbench/ltf_flags_tb_top.sv
// ltf_flags_tb_top: register-level tests of the ready and timeout flag bank
// assumes ltf_partner stands in for the transmitter and the wakeup generator
`timescale 1ns/10ps
module ltf_flags_tb_top;
    localparam int unsigned EXP = 20;
    logic        clk      = 1'b0;
    logic        arst_n   = 1'b0;
    logic [7:0]  addr     = 8'h00;
    logic [31:0] wdata    = 32'h0;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [3:0]  load_dly = 4'hf;
    logic        wake_go  = 1'b0;
    logic        brk_go   = 1'b0;
    logic [31:0] rdata, lo, hi;
    logic [7:0]  cbuf;
    logic        shift_load, tx_data_valid, wakeup_sent, synch_break, wakeup_hold, irq;
    logic [31:0] held [2] = '{32'h1f, 32'h1c};
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          n_cycles   = 0;

    always #2 clk = ~clk;

    ltf_flags #(.EXPIRY_CYCLES(EXP)) i_dut (.clk(clk), .arst_n(arst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .shift_load(shift_load),
        .tx_data_valid(tx_data_valid), .compat_tx_data_buffer(cbuf),
        .frame_tx_buffer_low(lo), .frame_tx_buffer_high(hi), .wakeup_sent(wakeup_sent),
        .synch_break(synch_break), .wakeup_hold(wakeup_hold), .irq(irq));
    ltf_partner i_far (.clk(clk), .arst_n(arst_n), .load_dly(load_dly), .wake_go(wake_go),
        .brk_go(brk_go), .tx_data_valid(tx_data_valid), .wakeup_hold(wakeup_hold),
        .shift_load(shift_load), .wakeup_sent(wakeup_sent), .synch_break(synch_break));

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd_chk
    // bounded wait, sel 0 watches the load pulse, 1 the expiry hold
    task automatic wait_on(input bit sel, input logic lvl);
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            if ((sel ? wakeup_hold : shift_load) === lvl) break;
        end
    endtask : wait_on
    task automatic kick(input bit brk);
        @(posedge clk);
        if (brk) brk_go <= 1'b1;
        else wake_go <= 1'b1;
        @(posedge clk);
        brk_go  <= 1'b0;
        wake_go <= 1'b0;
    endtask : kick
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        n_cycles++;
        if (n_cycles == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(ltf_pkg::OFS_FLAGS, 32'h100);
        rd_chk(8'h30, 32'h0);
        wr_reg(ltf_pkg::OFS_CTRL, 32'h12);
        wr_reg(ltf_pkg::OFS_IRQ_MASK, 32'h1);
        wr_reg(ltf_pkg::OFS_COMPAT_TD, 32'ha5);
        chk({24'h0, cbuf}, 32'ha5);
        rd_chk(ltf_pkg::OFS_FLAGS, 32'h0);
        wait_on(0, 1'b1);
        rd_chk(ltf_pkg::OFS_FLAGS, 32'h100);
        chk({31'h0, irq}, 32'h1);
        rd_chk(ltf_pkg::OFS_VECTOR, {24'h0, ltf_pkg::VEC_TX});
        rd_chk(ltf_pkg::OFS_FLAGS, 32'h100);
        wr_reg(ltf_pkg::OFS_IRQ_EN_CLR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // prompt shifter, then transmitter switched off
        @(posedge clk) load_dly <= 4'h0;
        wr_reg(ltf_pkg::OFS_IRQ_MASK, 32'h1);
        wr_reg(ltf_pkg::OFS_COMPAT_TD, 32'h3c);
        wait_on(0, 1'b1);
        rd_chk(ltf_pkg::OFS_IRQ_STAT, 32'h1);
        wr_reg(ltf_pkg::OFS_CTRL, 32'h02);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk) load_dly <= 4'hf;
        wr_reg(ltf_pkg::OFS_CTRL, 32'h1e);
        wr_reg(ltf_pkg::OFS_FRAME_LOUP, 32'h11223344);
        wr_reg(ltf_pkg::OFS_FRAME_HIGH, 32'h55667788);
        chk(hi, 32'h55667788);
        rd_chk(ltf_pkg::OFS_FLAGS, 32'h100);
        wr_reg(ltf_pkg::OFS_FRAME_LOW, 32'h000000aa);
        chk(lo, 32'h000000aa);
        rd_chk(ltf_pkg::OFS_FLAGS, 32'h0);
        wait_on(0, 1'b1);
        foreach (held[k]) begin
            wr_reg(ltf_pkg::OFS_FRAME_LOW, 32'h0);
            wr_reg(ltf_pkg::OFS_CTRL, held[k]);
            rd_chk(ltf_pkg::OFS_FLAGS, 32'h100);
            wr_reg(ltf_pkg::OFS_CTRL, 32'h1e);
        end
        // wakeup rounds with the timeout interrupt alone unmasked
        wr_reg(ltf_pkg::OFS_IRQ_STAT, 32'h3);
        wr_reg(ltf_pkg::OFS_IRQ_MASK, 32'h2);
        for (int r = 0; r < 2; r++) begin
            kick(1'b0);
            wait_on(1, 1'b1);
            wait_on(1, 1'b0);
            rd_chk(ltf_pkg::OFS_FLAGS, 32'h180);
            chk({31'h0, irq}, 32'h1);
            if (r == 0) rd_chk(ltf_pkg::OFS_VECTOR, {24'h0, ltf_pkg::VEC_TIMEOUT});
            if (r == 1) wr_reg(ltf_pkg::OFS_FLAGS, 32'h0);
            if (r == 1) rd_chk(ltf_pkg::OFS_FLAGS, 32'h180);
            if (r == 1) wr_reg(ltf_pkg::OFS_FLAGS, 32'h80);
            rd_chk(ltf_pkg::OFS_FLAGS, 32'h100);
        end
        kick(1'b0);
        wait_on(1, 1'b1);
        kick(1'b1);
        wait_on(1, 1'b0);
        rd_chk(ltf_pkg::OFS_FLAGS, 32'h100);
        wr_reg(ltf_pkg::OFS_CTRL, 32'h12);
        kick(1'b0);
        wait_on(1, 1'b1);
        chk({31'h0, wakeup_hold}, 32'h0);
        rd_chk(ltf_pkg::OFS_FLAGS, 32'h100);
        conclude();
    end
endmodule : ltf_flags_tb_top

// ### testbench/ltf_partner.sv
// ltf_partner: transmitter core and wakeup generator facing the flag bank
// assumes the bench steers load delay, wakeup rounds and break replies
`timescale 1ns/10ps
module ltf_partner (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // bench steering
    input  wire logic [3:0] load_dly,
    input  wire logic       wake_go,
    input  wire logic       brk_go,
    // flag bank side
    input  wire logic       tx_data_valid,
    input  wire logic       wakeup_hold,
    output logic            shift_load,
    output logic            wakeup_sent,
    output logic            synch_break
);
    logic [3:0] wait_q;
    logic [1:0] left_q;
    logic       take;
    assign take = tx_data_valid && !shift_load;
    // shifter idles load_dly cycles before taking the buffer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_q     <= 4'h0;
            shift_load <= 1'b0;
        end else begin
            shift_load <= take && wait_q == load_dly;
            wait_q     <= (take && wait_q != load_dly) ? wait_q + 4'h1 : 4'h0;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            left_q      <= 2'h0;
            wakeup_sent <= 1'b0;
            synch_break <= 1'b0;
        end else begin
            wakeup_sent <= left_q != 2'h0 && !wakeup_sent;
            synch_break <= brk_go;
            // no new round while the expiry still runs
            if (wake_go && !wakeup_hold && left_q == 2'h0) begin
                left_q <= ltf_pkg::WAKEUPS_ROUND;
            end else if (wakeup_sent) begin
                left_q <= left_q - 2'h1;
            end
        end
    end
endmodule : ltf_partner

// ### verilog/ltf_flags.sv
// ltf_flags: transmit-buffer-ready flag, triple-wakeup timeout flag, interrupts
// assumes one 250 MHz clock, a transmitter core that pulses when it loads the
// shift register and a wakeup generator that pulses per wakeup signal sent
//
// How it works
// - ready flag high while the active transmit buffer accepts characters
// - compat mode: any write of the compat data buffer clears ready
// - lin mode: only a write of byte zero of low buffer clears ready
// - ready sets when buffered data moves into the shift register
// - ready becoming set raises transmit interrupt when enabled
// - ready forced to one by reset bit, software release, system reset
// - reading the vector register never changes the ready flag
// - enable-clear write or transmitter disable withdraws pending transmit interrupt
// - ready zero means buffer full, one means ready for more
// - timeout flag works only in lin mode, stays clear otherwise
// - timeout flag sets after three wakeups, no break, then 1.5 s
// - no new wakeup round before the 1.5 s expiry has run out
// - timeout cleared by vector read, reset bits, system reset, write one
// - writing one clears timeout flag, writing zero does nothing
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
module ltf_flags #(
    parameter int unsigned EXPIRY_CYCLES = ltf_pkg::EXPIRY_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // transmitter side
    input  wire logic        shift_load,
    output logic             tx_data_valid,
    output logic      [7:0]  compat_tx_data_buffer,
    output logic      [31:0] frame_tx_buffer_low,
    output logic      [31:0] frame_tx_buffer_high,
    // wakeup side
    input  wire logic        wakeup_sent,
    input  wire logic        synch_break,
    output logic             wakeup_hold,
    // interrupt
    output logic             irq
);

    // ************************************************************
    // bus decode
    // ************************************************************
    ltf_pkg::ltf_req_s  req;
    ltf_pkg::ltf_ctrl_s ctrl_q;
    logic               held_in_reset;
    logic               release_rise;
    logic               sw_release_q;
    logic               wr_ctrl;
    logic               wr_flags;
    logic               wr_stat;
    logic               wr_mask;
    logic               wr_en_clr;
    logic               rd_vector;
    logic               wr_compat;
    logic               wr_low;
    logic               wr_loup;
    logic               wr_high;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign req       = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign wr_ctrl   = req.wr && hit(req.addr, ltf_pkg::OFS_CTRL);
    assign wr_flags  = req.wr && hit(req.addr, ltf_pkg::OFS_FLAGS);
    assign wr_stat   = req.wr && hit(req.addr, ltf_pkg::OFS_IRQ_STAT);
    assign wr_mask   = req.wr && hit(req.addr, ltf_pkg::OFS_IRQ_MASK);
    assign wr_en_clr = req.wr && hit(req.addr, ltf_pkg::OFS_IRQ_EN_CLR);
    assign rd_vector = req.rd && hit(req.addr, ltf_pkg::OFS_VECTOR);
    assign wr_compat = req.wr && hit(req.addr, ltf_pkg::OFS_COMPAT_TD);
    assign wr_low    = req.wr && hit(req.addr, ltf_pkg::OFS_FRAME_LOW);
    assign wr_loup   = req.wr && hit(req.addr, ltf_pkg::OFS_FRAME_LOUP);
    assign wr_high   = req.wr && hit(req.addr, ltf_pkg::OFS_FRAME_HIGH);

    // ************************************************************
    // control register
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q       <= ltf_pkg::CTRL_RESET;
            sw_release_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= req.wdata[4:0];
            end
            sw_release_q <= ctrl_q.sw_release;
        end
    end

    // logic is held while the reset bit is set or the release bit is low
    assign held_in_reset = ctrl_q.module_reset || !ctrl_q.sw_release;
    assign release_rise  = ctrl_q.sw_release && !sw_release_q;

    // ************************************************************
    // transmit buffers and ready flag
    // ************************************************************
    logic tx_ready_q;
    logic tx_clear;
    logic tx_set;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            compat_tx_data_buffer <= 8'h00;
            frame_tx_buffer_low   <= 32'h0000_0000;
            frame_tx_buffer_high  <= 32'h0000_0000;
        end else begin
            if (wr_compat) begin
                compat_tx_data_buffer <= req.wdata[7:0];
            end
            if (wr_low) begin
                frame_tx_buffer_low <= req.wdata;
            end
            if (wr_loup) begin
                frame_tx_buffer_low[31:8] <= req.wdata[31:8];
            end
            if (wr_high) begin
                frame_tx_buffer_high <= req.wdata;
            end
        end
    end

    // the upper-bytes offset never touches byte zero, so it never clears ready
    assign tx_clear = ctrl_q.lin_mode ? wr_low : wr_compat;
    assign tx_set   = shift_load && !tx_ready_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready_q <= ltf_pkg::TX_READY_RESET;
        end else if (held_in_reset || release_rise) begin
            tx_ready_q <= 1'b1;
        end else if (tx_set) begin
            tx_ready_q <= 1'b1;
        end else if (tx_clear) begin
            tx_ready_q <= 1'b0;
        end
    end

    // data waits in the buffer while the flag reads full
    assign tx_data_valid = !tx_ready_q && ctrl_q.tx_enable && !held_in_reset;

    // ************************************************************
    // triple wakeup timeout
    // ************************************************************
    typedef enum logic [1:0] {
        LTF_IDLE,
        LTF_COUNT,
        LTF_EXPIRY
    } ltf_wake_e;

    ltf_wake_e   wake_q;
    logic [1:0]  wakeups_q;
    logic [31:0] expiry_q;
    logic        timeout_q;
    logic        timeout_set;
    logic        timeout_clr;
    logic        lin_active;

    assign lin_active = ctrl_q.lin_mode && !held_in_reset;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_q    <= LTF_IDLE;
            wakeups_q <= 2'h0;
            expiry_q  <= 32'h0000_0000;
        end else if (!lin_active) begin
            wake_q    <= LTF_IDLE;
            wakeups_q <= 2'h0;
            expiry_q  <= 32'h0000_0000;
        end else begin
            unique case (wake_q)
                LTF_IDLE: begin
                    if (wakeup_sent) begin
                        wakeups_q <= 2'h1;
                        wake_q    <= LTF_COUNT;
                    end
                end
                LTF_COUNT: begin
                    if (synch_break) begin
                        wakeups_q <= 2'h0;
                        wake_q    <= LTF_IDLE;
                    end else if (wakeup_sent) begin
                        wakeups_q <= wakeups_q + 2'h1;
                        if (wakeups_q + 2'h1 == ltf_pkg::WAKEUPS_ROUND) begin
                            expiry_q <= 32'h0000_0000;
                            wake_q   <= LTF_EXPIRY;
                        end
                    end
                end
                LTF_EXPIRY: begin
                    if (synch_break) begin
                        wakeups_q <= 2'h0;
                        wake_q    <= LTF_IDLE;
                    end else if (expiry_q == EXPIRY_CYCLES - 1) begin
                        wakeups_q <= 2'h0;
                        wake_q    <= LTF_IDLE;
                    end else begin
                        expiry_q <= expiry_q + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // the wakeup generator must not start a round while the expiry runs
    assign wakeup_hold = (wake_q == LTF_EXPIRY);

    assign timeout_set = lin_active && (wake_q == LTF_EXPIRY) && !synch_break
                         && (expiry_q == EXPIRY_CYCLES - 1);

    // ************************************************************
    // vector register
    // ************************************************************
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [1:0] pending;
    logic [7:0] vector;

    assign pending = irq_stat_q & irq_mask_q;

    always_comb begin
        if (pending[ltf_pkg::IRQ_TIMEOUT]) begin
            vector = ltf_pkg::VEC_TIMEOUT;
        end else if (pending[ltf_pkg::IRQ_TX]) begin
            vector = ltf_pkg::VEC_TX;
        end else begin
            vector = ltf_pkg::VEC_NONE;
        end
    end

    // only the timeout source is acknowledged by a vector read
    assign timeout_clr = (wr_flags && req.wdata[ltf_pkg::FLAG_TRIPLE_TO])
                         || (rd_vector && vector == ltf_pkg::VEC_TIMEOUT);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_q <= 1'b0;
        end else if (!lin_active) begin
            timeout_q <= 1'b0;
        end else if (timeout_set) begin
            timeout_q <= 1'b1;
        end else if (timeout_clr) begin
            timeout_q <= 1'b0;
        end
    end

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    logic [1:0] stat_set;
    logic [1:0] stat_clr;

    assign stat_set[ltf_pkg::IRQ_TX]      = tx_set;
    assign stat_set[ltf_pkg::IRQ_TIMEOUT] = timeout_set;
    assign stat_clr[ltf_pkg::IRQ_TX]      = (wr_stat && req.wdata[ltf_pkg::IRQ_TX])
                                            || !ctrl_q.tx_enable
                                            || (wr_ctrl && !req.wdata[ltf_pkg::CTRL_TX_ENABLE])
                                            || (wr_en_clr && req.wdata[ltf_pkg::IRQ_TX]);
    assign stat_clr[ltf_pkg::IRQ_TIMEOUT] = (wr_stat && req.wdata[ltf_pkg::IRQ_TIMEOUT])
                                            || timeout_clr || !lin_active;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q <= stat_set | (irq_stat_q & ~stat_clr);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= ltf_pkg::IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_q <= req.wdata[1:0];
        end else if (wr_en_clr) begin
            irq_mask_q <= irq_mask_q & ~req.wdata[1:0];
        end
    end

    assign irq = |pending;

    // ************************************************************
    // read data, one cycle after the strobe
    // ************************************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (req.addr)
            ltf_pkg::OFS_CTRL:       rd_mux[4:0] = ctrl_q;
            ltf_pkg::OFS_FLAGS: begin
                rd_mux[ltf_pkg::FLAG_TX_READY]  = tx_ready_q;
                rd_mux[ltf_pkg::FLAG_TRIPLE_TO] = timeout_q;
            end
            ltf_pkg::OFS_IRQ_STAT:   rd_mux[1:0] = irq_stat_q;
            ltf_pkg::OFS_IRQ_MASK:   rd_mux[1:0] = irq_mask_q;
            ltf_pkg::OFS_VECTOR:     rd_mux[7:0] = vector;
            ltf_pkg::OFS_COMPAT_TD:  rd_mux[7:0] = compat_tx_data_buffer;
            ltf_pkg::OFS_FRAME_LOW:  rd_mux      = frame_tx_buffer_low;
            ltf_pkg::OFS_FRAME_HIGH: rd_mux      = frame_tx_buffer_high;
            default:                 rd_mux      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            rdata <= rd_mux;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule : ltf_flags

// ### verilog/ltf_pkg.sv
// ltf_pkg: constants and carrier types of the transmit-ready / wakeup-timeout flag bank
// assumes a plain register port with 8-bit byte addresses and 32-bit data
package ltf_pkg;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_FLAGS      = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN_CLR = 8'h10;
    localparam logic [7:0] OFS_VECTOR     = 8'h14;
    localparam logic [7:0] OFS_COMPAT_TD  = 8'h18;
    localparam logic [7:0] OFS_FRAME_LOW  = 8'h1c;
    localparam logic [7:0] OFS_FRAME_LOUP = 8'h20;
    localparam logic [7:0] OFS_FRAME_HIGH = 8'h24;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_MODULE_RESET = 0;
    localparam int CTRL_SW_RELEASE   = 1;
    localparam int CTRL_LIN_MODE     = 2;
    localparam int CTRL_MULTIBUFFER  = 3;
    localparam int CTRL_TX_ENABLE    = 4;
    localparam int FLAG_TX_READY     = 8;
    localparam int FLAG_TRIPLE_TO    = 7;
    localparam int IRQ_TX            = 0;
    localparam int IRQ_TIMEOUT       = 1;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [4:0]  CTRL_RESET     = 5'h00;
    localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;
    localparam logic        TX_READY_RESET = 1'b1;
    localparam logic [7:0]  VEC_NONE       = 8'h00;
    localparam logic [7:0]  VEC_TIMEOUT    = 8'h01;
    localparam logic [7:0]  VEC_TX         = 8'h02;
    localparam logic [1:0]  WAKEUPS_ROUND  = 2'h3;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_KHZ        = 250000;
    localparam int unsigned EXPIRY_MS      = 1500;
    localparam int unsigned EXPIRY_CYCLES  = EXPIRY_MS * CLK_KHZ;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ltf_req_s;

    typedef struct packed {
        logic tx_enable;
        logic multibuffer;
        logic lin_mode;
        logic sw_release;
        logic module_reset;
    } ltf_ctrl_s;

endpackage : ltf_pkg
